// File: reset_seq_pkg.sv
package reset_seq_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BOR_QUAL_US = 100;
  localparam int unsigned BOR_QUAL_CYCLES = BOR_QUAL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EXT_FILTER_NS = 2000;
  localparam int unsigned EXT_FILTER_CYCLES = (EXT_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS = 72;
  localparam int unsigned RC_OSC_HZ = 31_000;
  localparam int unsigned RC_DIV_CYCLES = CLK_HZ / RC_OSC_HZ;
  localparam int unsigned POWERUP_DELAY_TIMER_RC_TICKS = POWERUP_DELAY_TIMER_MS * RC_OSC_HZ / 1000;
  localparam int unsigned QUAL_CNT_W = 16;
  localparam int unsigned RC_DIV_W = 16;
  localparam int unsigned POWERUP_DELAY_TIMER_CNT_W = 16;

  // register indexes; byte address is four times the index
  localparam logic [11:0] FLAGS_IDX = 12'h08e;
  localparam logic [11:0] RETAIN_IDX = 12'h08f;
  localparam logic [11:0] STATUS_IDX = 12'h090;
  localparam logic [11:0] FLAGS_ADDR = {FLAGS_IDX[9:0], 2'b00};
  localparam logic [11:0] RETAIN_ADDR = {RETAIN_IDX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};

  // field positions
  localparam int unsigned FLAG_BOR_BIT = 0;
  localparam int unsigned FLAG_POR_BIT = 1;
  localparam int unsigned ST_TO_BIT = 0;
  localparam int unsigned ST_PD_BIT = 1;
  localparam int unsigned ST_PIN_BIT = 2;
  localparam int unsigned ST_PINEN_BIT = 3;
  localparam int unsigned ST_STATE_LSB = 4;

  // values after reset
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic TO_RESET = 1'b1;
  localparam logic PD_RESET = 1'b1;

  typedef enum logic [1:0] {
    SEQ_HOLD_SUPPLY,
    SEQ_POWERUP_DELAY_TIMER,
    SEQ_START,
    SEQ_RUN
  } seq_state_e;
endpackage

// File: level_qualify.sv
`timescale 1ns/1ps
`default_nettype none
module level_qualify
  import reset_seq_pkg::*;
#(
  parameter int unsigned CYCLES = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic qualified_out
);
  logic [QUAL_CNT_W-1:0] count_r;
  logic [QUAL_CNT_W-1:0] count_nxt;
  wire logic at_limit = (count_r == QUAL_CNT_W'(CYCLES - 1));

  // any gap in the level restarts the count, so short pulses never qualify
  always_comb begin
    if (!level_in) begin
      count_nxt = '0;
    end else if (at_limit) begin
      count_nxt = count_r;
    end else begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count_r <= '0;
      qualified_out <= 1'b0;
    end else begin
      count_r <= count_nxt;
      qualified_out <= level_in & at_limit;
    end
  end
endmodule
`default_nettype wire

// File: reset_source_sequencer.sv
// Function
// [R1] six reset sources are accepted
// [R2] retained register survives all but power-on; the code never resets it, not even on power-on
// [R3] other registers reset on every reset
// [R4] watchdog wake resumes, no register reset
// [R5] timeout/powerdown flags per reset kind
// [R6] cause flags record power-on and brown-out
// [R7] external pin filtered against short pulses
// [R8] watchdog reset never drives the pin
// [R9] pin enable selects external or internal reset
// [R10] brown-out enabled by configuration bit
// [R11] brown-out needs 100 us qualified dip
// [R12] reset held until supply above brown-out
// [R13] power-up delay adds 72 ms hold
// [R14] dip during delay restarts full delay
// [R15] brown-out off or sleep: power-on only
// [R16] delay from internal oscillator, power-up only
// [R17] delay-off bit set disables the delay
// [R18] run needs delay, oscillator, pin released
// [R19] delay disabled means no timeout
// [R20] timeouts run independently of reset pin
// [R21] watchdog reset updates timeout flags
// [R22] brown-out inactive during sleep
// [R23] software sets power-on flag after power-on
// [R24] pin disabled acts as digital input
// [R25] delay counter scaled by oscillator frequency
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer
  import reset_seq_pkg::*;
#(
  parameter int unsigned BOR_QUAL_CYC = BOR_QUAL_CYCLES,
  parameter int unsigned RC_DIV_CYC = RC_DIV_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic poweron_detect_in,
  input wire logic supply_above_bor_in,
  input wire logic external_reset_pin_in,
  input wire logic watchdog_timeout_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic sleep_instruction_in,
  input wire logic sleep_in,
  input wire logic osc_start_done_in,
  input wire logic brownout_enable_in,
  input wire logic ext_reset_pin_enable_in,
  input wire logic powerup_delay_off_in,
  output logic core_reset_out,
  output logic reg_reset_out,
  output logic watchdog_wake_out,
  output logic ext_pin_pullup_out,
  output logic ext_pin_digital_out,
  output logic watchdog_timeout_flag_n_out,
  output logic powerdown_flag_n_out
);
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic por_flag_r;
  logic bor_flag_r;
  logic to_r;
  logic pd_r;
  logic [7:0] retain_r;
  logic powerup_delay_timer_wanted_r;
  logic pin_low_q;
  logic bor_q;
  logic [RC_DIV_W-1:0] rc_div_r;
  logic [POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // source qualification
  wire logic bor_active = brownout_enable_in & ~sleep_in; // [R10] [R22] [R15]
  wire logic bor_dip = bor_active & ~supply_above_bor_in;
  wire logic pin_enabled = ext_reset_pin_enable_in; // [R9]
  wire logic pin_reset = pin_enabled & pin_low_q; // [R24]
  wire logic pin_reset_run = pin_reset & ~sleep_in;
  wire logic pin_reset_sleep = pin_reset & sleep_in;
  wire logic wdt_reset = watchdog_timeout_in & ~sleep_in; // [R21]
  wire logic wdt_wake = watchdog_timeout_in & sleep_in; // [R4]
  wire logic por_event = poweron_detect_in;
  wire logic bor_event = bor_q & ~por_event;
  wire logic any_reset = por_event | bor_event | pin_reset | wdt_reset; // [R1]

  // pulse filter on the pin; only a sustained low counts
  level_qualify #(.CYCLES(EXT_FILTER_CYCLES)) pin_filter ( // [R7]
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .level_in(~external_reset_pin_in),
    .qualified_out(pin_low_q)
  );

  // brown-out must persist for the qualification time
  level_qualify #(.CYCLES(BOR_QUAL_CYC)) bor_filter ( // [R11]
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .level_in(bor_dip),
    .qualified_out(bor_q)
  );

  // internal oscillator tick: delay counts oscillator periods, not system clocks
  wire logic rc_tick = (rc_div_r == RC_DIV_W'(RC_DIV_CYC - 1)); // [R25]
  wire logic powerup_delay_timer_done = (powerup_delay_timer_cnt_r == POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_RC_TICKS)); // [R16]
  wire logic powerup_delay_timer_enabled = ~powerup_delay_off_in; // [R17]
  wire logic pin_released = ~pin_reset; // [R18]

  // sequencing; a power-on or brown-out always wins over other sources
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEQ_HOLD_SUPPLY: begin
        if (supply_above_bor_in && !por_event) begin // [R12]
          if (powerup_delay_timer_enabled && powerup_delay_timer_wanted_r) begin // [R13]
            state_nxt = SEQ_POWERUP_DELAY_TIMER;
          end else begin
            state_nxt = SEQ_START; // [R19]
          end
        end
      end
      SEQ_POWERUP_DELAY_TIMER: begin
        if (bor_active && !supply_above_bor_in) begin
          state_nxt = SEQ_HOLD_SUPPLY; // [R14]
        end else if (powerup_delay_timer_done) begin
          state_nxt = SEQ_START;
        end
      end
      SEQ_START: begin
        if (osc_start_done_in && pin_released) begin // [R18] [R20]
          state_nxt = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (pin_reset || wdt_reset) begin
          state_nxt = SEQ_START;
        end
      end
      default: begin
        state_nxt = SEQ_HOLD_SUPPLY;
      end
    endcase
    if (por_event || bor_event) begin
      state_nxt = SEQ_HOLD_SUPPLY;
    end
  end

  // sequencer state and delay counters
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= SEQ_HOLD_SUPPLY;
      powerup_delay_timer_wanted_r <= 1'b1;
      rc_div_r <= '0;
      powerup_delay_timer_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (por_event || bor_event) begin
        powerup_delay_timer_wanted_r <= 1'b1; // [R16]
      end else if (state_r == SEQ_RUN) begin
        powerup_delay_timer_wanted_r <= 1'b0;
      end
      // the count ignores the pin so the delay can expire under a held pin
      if (state_r != SEQ_POWERUP_DELAY_TIMER) begin
        rc_div_r <= '0; // [R14]
        powerup_delay_timer_cnt_r <= '0; // [R14]
      end else begin
        rc_div_r <= rc_tick ? '0 : rc_div_r + 1'b1; // [R20]
        if (rc_tick && !powerup_delay_timer_done) begin
          powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + 1'b1;
        end
      end
    end
  end

  // core reset, register reset and wake outputs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      core_reset_out <= 1'b1;
      reg_reset_out <= 1'b1;
      watchdog_wake_out <= 1'b0;
      ext_pin_pullup_out <= 1'b0;
      ext_pin_digital_out <= 1'b1;
    end else begin
      core_reset_out <= (state_nxt != SEQ_RUN);
      reg_reset_out <= any_reset; // [R3]
      watchdog_wake_out <= wdt_wake; // [R4]
      ext_pin_pullup_out <= pin_enabled; // [R9]
      ext_pin_digital_out <= external_reset_pin_in; // [R24]
    end
  end
  // watchdog reset is internal only; no pin drive exists in this block [R8]

  // timeout/powerdown flags; hardware events take priority in listed order
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      to_r <= TO_RESET;
      pd_r <= PD_RESET;
    end else if (por_event || bor_event) begin
      to_r <= 1'b1; // [R5]
      pd_r <= 1'b1; // [R5]
    end else if (wdt_reset) begin
      to_r <= 1'b0; // [R5] [R21]
    end else if (wdt_wake) begin
      to_r <= 1'b0; // [R5]
      pd_r <= 1'b0; // [R5]
    end else if (pin_reset_sleep) begin
      to_r <= 1'b1; // [R5]
      pd_r <= 1'b0; // [R5]
    end else if (pin_reset_run) begin
      to_r <= to_r; // [R5]
    end else if (watchdog_clear_instruction_in) begin
      to_r <= 1'b1;
      pd_r <= 1'b1;
    end else if (sleep_instruction_in) begin
      to_r <= 1'b1;
      pd_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      watchdog_timeout_flag_n_out <= TO_RESET;
      powerdown_flag_n_out <= PD_RESET;
    end else begin
      watchdog_timeout_flag_n_out <= to_r;
      powerdown_flag_n_out <= pd_r;
    end
  end

  // register decode; access completes on the second access-phase edge
  wire logic apb_access = psel_in & penable_in;
  wire logic apb_done = apb_access & pready_r;
  wire logic hit_flags = (paddr_in == FLAGS_ADDR);
  wire logic hit_retain = (paddr_in == RETAIN_ADDR);
  wire logic hit_status = (paddr_in == STATUS_ADDR);
  wire logic unmapped = ~(hit_flags | hit_retain | hit_status);
  wire logic wr_flags = apb_done & pwrite_in & hit_flags;
  wire logic wr_retain = apb_done & pwrite_in & hit_retain;
  wire logic [31:0] rd_flags = {30'h0, por_flag_r, bor_flag_r};
  wire logic [31:0] rd_status = {26'h0, state_r, pin_enabled, ext_pin_digital_out, pd_r, to_r};
  wire logic [31:0] rd_mux = hit_flags ? rd_flags : hit_retain ? {24'h0, retain_r} : hit_status ? rd_status : 32'h0;

  // cause flags: a power-on or brown-out event beats a software write in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      por_flag_r <= FLAGS_RESET[FLAG_POR_BIT];
      bor_flag_r <= FLAGS_RESET[FLAG_BOR_BIT];
    end else if (por_event) begin
      por_flag_r <= 1'b0; // [R6]
      bor_flag_r <= 1'b0;
    end else if (bor_event) begin
      bor_flag_r <= 1'b0; // [R6]
    end else if (wr_flags) begin
      por_flag_r <= pwdata_in[FLAG_POR_BIT]; // [R23]
      bor_flag_r <= pwdata_in[FLAG_BOR_BIT];
    end
  end

  // retained word: no reset term at all, so it holds through every reset
  always_ff @(posedge sys_clk_in) begin
    if (wr_retain) begin
      retain_r <= pwdata_in[7:0]; // [R2]
    end
  end

  // apb slave: one wait state, error on unmapped addresses
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apb_access & ~pready_r;
      pslverr_r <= apb_access & ~pready_r & unmapped;
      prdata_r <= (apb_access & ~pready_r & ~pwrite_in) ? rd_mux : 32'h0;
    end
  end

  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out = prdata_r;
endmodule
`default_nettype wire

// File: reset_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module reset_seq_sva (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic poweron_detect_in,
  input wire logic supply_above_bor_in,
  input wire logic watchdog_timeout_in,
  input wire logic sleep_in,
  input wire logic osc_start_done_in,
  input wire logic ext_reset_pin_enable_in,
  input wire logic external_reset_pin_in,
  input wire logic core_reset_out,
  input wire logic reg_reset_out,
  input wire logic watchdog_wake_out,
  input wire logic ext_pin_pullup_out,
  input wire logic ext_pin_digital_out,
  input wire logic watchdog_timeout_flag_n_out,
  input wire logic powerdown_flag_n_out
);
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // flags lag the internal state by one cycle
  property p_por;
    poweron_detect_in |=> core_reset_out ##1 (watchdog_timeout_flag_n_out && powerdown_flag_n_out);
  endproperty
  a_por: assert property (p_por) else $error("power-on hold or flags");
  property p_supply;
    core_reset_out && !supply_above_bor_in |=> core_reset_out;
  endproperty
  a_supply: assert property (p_supply) else $error("left reset on low supply");
  property p_osc;
    core_reset_out && !osc_start_done_in |=> core_reset_out;
  endproperty
  a_osc: assert property (p_osc) else $error("ran before oscillator");
  property p_wake;
    watchdog_timeout_in && sleep_in && !core_reset_out |=> watchdog_wake_out && !reg_reset_out && !core_reset_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not clean");
  property p_wdrst;
    watchdog_timeout_in && !sleep_in && !core_reset_out |=> reg_reset_out && core_reset_out ##1
      !watchdog_timeout_flag_n_out;
  endproperty
  a_wdrst: assert property (p_wdrst) else $error("watchdog reset wrong");
  property p_wdpin;
    watchdog_timeout_in && ext_reset_pin_enable_in |=> ext_pin_pullup_out;
  endproperty
  a_wdpin: assert property (p_wdpin) else $error("watchdog touched pin");
  property p_pinoff;
    !ext_reset_pin_enable_in |=> !ext_pin_pullup_out;
  endproperty
  a_pinoff: assert property (p_pinoff) else $error("pull-up while disabled");
  property p_digin;
    !ext_reset_pin_enable_in |=> ext_pin_digital_out == $past(external_reset_pin_in);
  endproperty
  a_digin: assert property (p_digin) else $error("digital input wrong");
endmodule
`default_nettype wire

// File: supply_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
  input wire logic clk_in,
  input wire logic vdd_low_in,
  input wire logic vdd_dip_in,
  input wire logic pin_low_in,
  input wire logic pullup_in,
  output logic poweron_detect_out,
  output logic supply_above_bor_out,
  output logic pin_out,
  output logic osc_done_out
);
  logic [3:0] osc_cnt_r;
  // comparators and start-up timer track the supply
  always_ff @(posedge clk_in) begin
    poweron_detect_out <= vdd_low_in;
    supply_above_bor_out <= !vdd_low_in && !vdd_dip_in;
    osc_cnt_r <= vdd_low_in ? 4'h0 : osc_cnt_r + {3'h0, ~&osc_cnt_r};
    osc_done_out <= &osc_cnt_r;
    // released pin floats unless pulled up, so never keeps old level
    pin_out <= pin_low_in ? 1'b0 : (pullup_in ? 1'b1 : ~pin_out);
  end
endmodule
`default_nettype wire

// File: reset_source_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int DLY = POWERUP_DELAY_TIMER_RC_TICKS * 2;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, watchdog_clear_instruction_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, q;
  logic err_seen;
  logic pready_out, pslverr_out, poweron_detect_in, supply_above_bor_in, external_reset_pin_in, osc_start_done_in;
  logic watchdog_timeout_in = 1'b0, sleep_instruction_in = 1'b0, sleep_in = 1'b0, brownout_enable_in = 1'b1;
  logic ext_reset_pin_enable_in = 1'b1, powerup_delay_off_in = 1'b0, vdd_low = 1'b1, vdd_dip = 1'b0, pin_low = 1'b1;
  logic core_reset_out, reg_reset_out, watchdog_wake_out, ext_pin_pullup_out, ext_pin_digital_out;
  logic watchdog_timeout_flag_n_out, powerdown_flag_n_out;
  int bad_count = 0, total_checks = 0, n;
  always #2.5 sys_clk_in = ~sys_clk_in;
  supply_pin_model far (.clk_in(sys_clk_in), .vdd_low_in(vdd_low), .vdd_dip_in(vdd_dip), .pin_low_in(pin_low),
    .pullup_in(ext_pin_pullup_out), .poweron_detect_out(poweron_detect_in), .supply_above_bor_out(supply_above_bor_in),
    .pin_out(external_reset_pin_in), .osc_done_out(osc_start_done_in));
  reset_source_sequencer #(.BOR_QUAL_CYC(8), .RC_DIV_CYC(2)) dut (.*);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer, held until pready is seen at an edge; reads compare the whole data word
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input string what);
    int k;
    k = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    chk("pready", 32'h1, {31'h0, pready_out});
    q = prdata_out;
    err_seen = pslverr_out;
    if (!wr) chk(what, d, q);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  task automatic core_is(input logic e, input string what);
    chk(what, {31'h0, e}, {31'h0, core_reset_out});
  endtask
  // bounded wait for the core to leave reset
  task automatic run_by(input int lim, input string what);
    n = 0;
    while (core_reset_out !== 1'b0 && n < lim) begin
      wait_cyc(1);
      n++;
    end
    core_is(1'b0, what);
  endtask
  task automatic wd_pulse;
    watchdog_timeout_in <= 1'b1;
    wait_cyc(1);
    watchdog_timeout_in <= 1'b0;
    wait_cyc(3);
  endtask
  task automatic pin_hold(input int c);
    pin_low <= 1'b1;
    wait_cyc(c);
    pin_low <= 1'b0;
    wait_cyc(2);
  endtask
  task automatic dip(input int c);
    vdd_dip <= 1'b1;
    wait_cyc(c);
    vdd_dip <= 1'b0;
    wait_cyc(4);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #150000;
    bad_count++;
    summarize();
  end
  initial begin
    wait_cyc(8);
    rst_in <= 1'b0;
    wait_cyc(1);
    apb(1'b0, FLAGS_ADDR, 32'h0, "flags por");
    // pin held low past the delay, then released
    vdd_low <= 1'b0;
    wait_cyc(DLY + 300);
    core_is(1'b1, "pin hold");
    pin_low <= 1'b0;
    run_by(600, "pin release");
    apb(1'b1, FLAGS_ADDR, 32'h3, "");
    apb(1'b1, RETAIN_ADDR, 32'h5a, "");
    apb(1'b0, 12'h004, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err_seen});
    dip(5);
    core_is(1'b0, "short dip");
    brownout_enable_in <= 1'b0;
    dip(30);
    core_is(1'b0, "bor off");
    brownout_enable_in <= 1'b1;
    dip(30);
    core_is(1'b1, "brown-out");
    apb(1'b0, FLAGS_ADDR, 32'h2, "flags bor");
    wait_cyc(2000);
    core_is(1'b1, "delay");
    dip(30);
    run_by(DLY + 300, "restart");
    chk("restart len", 32'h1, {31'h0, n > DLY - 20});
    wd_pulse();
    run_by(50, "wd run");
    // run state, pin enabled and high, powerdown set, timeout cleared
    apb(1'b0, STATUS_ADDR, 32'h0000003e, "st wd");
    apb(1'b0, RETAIN_ADDR, 32'h5a, "retain");
    apb(1'b0, FLAGS_ADDR, 32'h2, "flags wd");
    pin_hold(100);
    core_is(1'b0, "short pin");
    pin_hold(450);
    run_by(600, "pin run");
    chk("flags pin run", 32'h1, {30'h0, watchdog_timeout_flag_n_out, powerdown_flag_n_out});
    sleep_instruction_in <= 1'b1;
    wait_cyc(1);
    sleep_instruction_in <= 1'b0;
    sleep_in <= 1'b1;
    wd_pulse();
    core_is(1'b0, "wake");
    chk("flags wake", 32'h0, {30'h0, watchdog_timeout_flag_n_out, powerdown_flag_n_out});
    pin_hold(450);
    sleep_in <= 1'b0;
    run_by(600, "pin sleep");
    chk("flags pin sleep", 32'h2, {30'h0, watchdog_timeout_flag_n_out, powerdown_flag_n_out});
    ext_reset_pin_enable_in <= 1'b0;
    pin_hold(450);
    core_is(1'b0, "pin off");
    chk("pullup off", 32'h0, {31'h0, ext_pin_pullup_out});
    ext_reset_pin_enable_in <= 1'b1;
    powerup_delay_off_in <= 1'b1;
    vdd_low <= 1'b1;
    wait_cyc(4);
    vdd_low <= 1'b0;
    run_by(100, "no delay");
    chk("flags no delay", 32'h3, {30'h0, watchdog_timeout_flag_n_out, powerdown_flag_n_out});
    apb(1'b0, FLAGS_ADDR, 32'h0, "flags por again");
    summarize();
  end
endmodule
bind reset_source_sequencer reset_seq_sva chk_i (.sys_clk_in, .rst_in, .poweron_detect_in, .supply_above_bor_in,
  .watchdog_timeout_in, .sleep_in, .osc_start_done_in, .ext_reset_pin_enable_in, .external_reset_pin_in,
  .core_reset_out, .reg_reset_out, .watchdog_wake_out, .ext_pin_pullup_out, .ext_pin_digital_out,
  .watchdog_timeout_flag_n_out, .powerdown_flag_n_out);
`default_nettype wire
